// *** core/aioc_ctrl.sv ***
// analog i/o configuration control: config bits and analog routing selects
//
// Behaviour
// - seven software bits set output polarity and coding, input range and mode
// - reset: grounded single ended, all bipolar
// - each output channel has own polarity
// - each output converter has own coding
// - three modes; eight or four channels
// - paired mode uses even/odd channel pairs
// - grounded mode: negative input to ground
// - sensed mode: negative input to sense pin
// - backplane bus select, off after reset
// - bus selected: paired routing, mode ignored
// - bus selected: gain and polarity still apply
// - host port interrupt line signals acquisition
// - input range and result coding selectable
`timescale 1ns/1ps
module aioc_ctrl
   import aioc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // configuration write from the host port link (asynchronous pins)
   input wire logic cfg_wr_i,
   input wire logic [6:0] cfg_data_i,
   input wire logic bus_sel_i,
   input wire logic in_bin_i,
   // channel select and gain from the acquisition logic
   input wire logic [2:0] chan_i,
   input wire logic [1:0] gain_i,
   // acquisition event to report to host
   input wire logic acq_done_i,
   input wire logic irq_ack_i,
   // configuration readback
   output logic [6:0] cfg_o,
   output logic backplane_analog_bus_select_o,
   output logic in_bin_o,
   // output converter settings
   output logic out0_unipolar_o,
   output logic out1_unipolar_o,
   output logic out0_binary_o,
   output logic out1_binary_o,
   // input amplifier routing
   output logic in_unipolar_o,
   output logic [1:0] in_gain_o,
   output logic [2:0] pos_chan_o,
   output logic pos_from_bus_o,
   output logic [1:0] neg_route_o,
   output logic [2:0] neg_chan_o,
   output logic input_sense_ground_pin_oe_o,
   output logic [3:0] chan_count_o,
   // host port interrupt line
   output logic host_irq_o
);
   import aioc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // synchronisation of the host link pins

   // pin group: strobe, bus select, result coding, seven bits
   logic [9:0] pins_raw;
   logic [9:0] pins_s;
   assign pins_raw = {cfg_wr_i, bus_sel_i, in_bin_i, cfg_data_i};

   aioc_sync #(.W(10)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // state

   // whole module state in one struct
   typedef struct packed {
      logic wr_q;          // last synchronised strobe, for edge
      logic [6:0] cfg;     // seven configuration bits
      logic bus_sel;       // backplane bus routed to amplifier
      logic in_bin;        // input result coding
      logic out0_uni;
      logic out1_uni;
      logic out0_bin;
      logic out1_bin;
      logic in_uni;
      logic [1:0] gain;
      logic [2:0] pos;
      logic pos_bus;
      logic [1:0] neg;
      logic [2:0] negch;
      logic sense_oe;
      logic [3:0] count;
      logic irq;
   } aioc_state_t;

   aioc_state_t st;
   aioc_state_t next_st;

   // mode field extraction, used for the live and the next value
   function automatic logic [1:0] mode_of(input logic [6:0] c);
      mode_of = c[POS_MODE_HI:POS_MODE_LO];
   endfunction : mode_of

   // live config value after this cycle's write
   logic [6:0] cfg_now;
   logic bus_now;
   logic [1:0] mode_now;

   ////////////////////////////////////////////////////////////////////////
   // next state logic

   // routing is decoded from the freshly written value so the analog
   // path follows the write within one cycle
   always_comb begin
      next_st = st;
      next_st.wr_q = pins_s[9];
      // capture on rising strobe edge only; level held otherwise
      if (pins_s[9] && !st.wr_q) begin
         next_st.cfg = pins_s[6:0];
         next_st.bus_sel = pins_s[8];
         next_st.in_bin = pins_s[7];
      end
      cfg_now = next_st.cfg;
      bus_now = next_st.bus_sel;
      mode_now = mode_of(cfg_now);
      // output converters, independent per channel
      next_st.out0_uni = cfg_now[POS_OUT0_UNI];
      next_st.out1_uni = cfg_now[POS_OUT1_UNI];
      next_st.out0_bin = cfg_now[POS_OUT0_BIN];
      next_st.out1_bin = cfg_now[POS_OUT1_BIN];
      // range and gain always apply, bus or not
      next_st.in_uni = cfg_now[POS_IN_UNI];
      next_st.gain = gain_i;
      // defaults: grounded single ended
      next_st.pos = chan_i;
      next_st.pos_bus = 1'b0;
      next_st.neg = NEG_GROUND;
      next_st.negch = 3'h0;
      next_st.sense_oe = 1'b1;
      next_st.count = CHANS_SINGLE;
      if (bus_now) begin
         // bus pair, mode field ignored
         next_st.pos_bus = 1'b1;
         next_st.neg = NEG_BUS;
         next_st.sense_oe = 1'b0;
         next_st.count = CHANS_PAIRED;
      end else begin
         unique case (mode_now)
            MODE_GROUNDED: begin
               next_st.neg = NEG_GROUND;
            end
            MODE_SENSED: begin
               // pin is a sense input here, not ground
               next_st.neg = NEG_SENSE;
               next_st.sense_oe = 1'b0;
            end
            MODE_PAIRED: begin
               next_st.pos = {chan_i[1:0], 1'b0};
               next_st.negch = {chan_i[1:0], 1'b1};
               next_st.neg = NEG_CHAN;
               next_st.count = CHANS_PAIRED;
            end
            default: begin
               // illegal code 3: fall back to grounded single ended
               next_st.neg = NEG_GROUND;
            end
         endcase
      end
      // interrupt: set wins over acknowledge
      if (acq_done_i) begin
         next_st.irq = 1'b1;
      end else if (irq_ack_i) begin
         next_st.irq = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   // reset gives the shipped configuration
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.cfg <= RST_CFG;
         st.bus_sel <= RST_BUS_SEL;
         st.in_bin <= RST_IN_BIN;
         st.count <= CHANS_SINGLE;
         st.sense_oe <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state flip-flops
   assign cfg_o = st.cfg;
   assign backplane_analog_bus_select_o = st.bus_sel;
   assign in_bin_o = st.in_bin;
   assign out0_unipolar_o = st.out0_uni;
   assign out1_unipolar_o = st.out1_uni;
   assign out0_binary_o = st.out0_bin;
   assign out1_binary_o = st.out1_bin;
   assign in_unipolar_o = st.in_uni;
   assign in_gain_o = st.gain;
   assign pos_chan_o = st.pos;
   assign pos_from_bus_o = st.pos_bus;
   assign neg_route_o = st.neg;
   assign neg_chan_o = st.negch;
   assign input_sense_ground_pin_oe_o = st.sense_oe;
   assign chan_count_o = st.count;
   assign host_irq_o = st.irq;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   // a write strobe edge seen on the synchronised strobe
   sequence s_wr_edge;
      pins_s[9] && !st.wr_q;
   endsequence

   a_cfg_capture: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      s_wr_edge |=> (st.cfg == $past(pins_s[6:0])))
      else $error("config not captured on write");

   a_cfg_hold: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !(pins_s[9] && !st.wr_q) |=> $stable(st.cfg))
      else $error("config changed without write");

   a_out_follow: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      s_wr_edge |=> (out0_unipolar_o == $past(pins_s[POS_OUT0_UNI])
         && out1_unipolar_o == $past(pins_s[POS_OUT1_UNI])))
      else $error("output polarity not following config");

   a_code_follow: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      s_wr_edge |=> (out0_binary_o == $past(pins_s[POS_OUT0_BIN])
         && out1_binary_o == $past(pins_s[POS_OUT1_BIN])))
      else $error("output coding not following config");

   a_paired_route: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (neg_route_o == NEG_CHAN) |->
         (pos_chan_o[0] == 1'b0 && neg_chan_o == (pos_chan_o | 3'h1)
          && chan_count_o == CHANS_PAIRED))
      else $error("paired routing not even/odd");

   a_ground_route: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!st.bus_sel && mode_of(st.cfg) == MODE_GROUNDED) |->
         (neg_route_o == NEG_GROUND && chan_count_o == CHANS_SINGLE))
      else $error("grounded mode negative not at ground");

   a_sense_route: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!st.bus_sel && mode_of(st.cfg) == MODE_SENSED) |->
         (neg_route_o == NEG_SENSE && !input_sense_ground_pin_oe_o))
      else $error("sensed mode negative not at sense pin");

   a_bus_route: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      st.bus_sel |-> (pos_from_bus_o && neg_route_o == NEG_BUS))
      else $error("bus select not routing bus pair");

   a_bus_range: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      st.bus_sel |-> (in_unipolar_o == st.cfg[POS_IN_UNI]))
      else $error("range ignored while bus selected");

   a_irq_set: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      acq_done_i |=> host_irq_o)
      else $error("interrupt not raised on acquisition event");

   // acknowledge alone drops the line one cycle later
   a_irq_clear: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (irq_ack_i && !acq_done_i) |=> !host_irq_o)
      else $error("interrupt not cleared by acknowledge");

   // paired mode gives four channel pairs
   a_paired_count: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!st.bus_sel && mode_of(st.cfg) == MODE_PAIRED) |->
         (neg_route_o == NEG_CHAN && chan_count_o == CHANS_PAIRED))
      else $error("paired mode not four channel pairs");

   // gain still passes through with the bus routed in
   a_bus_gain: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      st.bus_sel |=> (in_gain_o == $past(gain_i)))
      else $error("gain ignored while bus selected");

   // bus select only moves on a strobe edge
   a_bus_hold: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      !(pins_s[9] && !st.wr_q) |=> $stable(st.bus_sel))
      else $error("bus select changed without write");
endmodule : aioc_ctrl

// *** core/aioc_pkg.sv ***
// package: constants and types for the analog i/o configuration control
package aioc_pkg;
   // number of software-writable configuration bits
   localparam int CFG_BITS = 7;
   // field positions inside the configuration word
   localparam int POS_OUT0_UNI = 0;
   localparam int POS_OUT1_UNI = 1;
   localparam int POS_OUT0_BIN = 2;
   localparam int POS_OUT1_BIN = 3;
   localparam int POS_IN_UNI = 4;
   localparam int POS_MODE_LO = 5;
   localparam int POS_MODE_HI = 6;
   // input mode field codes
   localparam logic [1:0] MODE_GROUNDED = 2'h0;
   localparam logic [1:0] MODE_SENSED = 2'h1;
   localparam logic [1:0] MODE_PAIRED = 2'h2;
   // separate config bits beyond the seven
   localparam logic RST_BUS_SEL = 1'h0;
   localparam logic RST_IN_BIN = 1'h0;
   // reset value: grounded single ended, all bipolar, two's complement
   localparam logic [6:0] RST_CFG = 7'h00;
   // channel counts per mode
   localparam logic [3:0] CHANS_SINGLE = 4'h8;
   localparam logic [3:0] CHANS_PAIRED = 4'h4;
   // negative input routing codes
   localparam logic [1:0] NEG_GROUND = 2'h0;
   localparam logic [1:0] NEG_SENSE = 2'h1;
   localparam logic [1:0] NEG_CHAN = 2'h2;
   localparam logic [1:0] NEG_BUS = 2'h3;
   // write strobe from host port link, synchronised
   localparam int SYNC_STAGES = 2;
endpackage : aioc_pkg

// *** core/aioc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aioc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // first stage read only by the second
   logic [W-1:0] meta;

   // plain two stage chain
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule : aioc_sync

// *** verification/aioc_ctrl_tb_top.sv ***
// testbench for the analog i/o configuration control block
`timescale 1ns/1ps
module aioc_ctrl_tb_top;
   import aioc_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // stimulus and observed outputs
   logic clk_sys_i;
   logic rst_i;
   logic cfg_wr_i;
   logic [6:0] cfg_data_i;
   logic bus_sel_i;
   logic in_bin_i;
   logic [2:0] chan_i;
   logic [1:0] gain_i;
   logic acq_done_i;
   logic irq_ack_i;
   logic [6:0] cfg_o;
   logic bsel, ibin, o0u, o1u, o0b, o1b, iuni, pbus, oe, irq;
   logic [1:0] igain, nroute;
   logic [2:0] pchan, nchan;
   logic [3:0] ccount;
   int n_fail;
   int n_compared;
   int n_cycles;
   logic [4:0] opts [4] = '{5'h05, 5'h1a, 5'h13, 5'h0c};
   ////////////////////////////////////////////////////////////////////////
   aioc_ctrl u_dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
      .cfg_data_i(cfg_data_i), .bus_sel_i(bus_sel_i), .in_bin_i(in_bin_i),
      .chan_i(chan_i), .gain_i(gain_i), .acq_done_i(acq_done_i),
      .irq_ack_i(irq_ack_i), .cfg_o(cfg_o),
      .backplane_analog_bus_select_o(bsel), .in_bin_o(ibin),
      .out0_unipolar_o(o0u), .out1_unipolar_o(o1u),
      .out0_binary_o(o0b), .out1_binary_o(o1b),
      .in_unipolar_o(iuni), .in_gain_o(igain), .pos_chan_o(pchan),
      .pos_from_bus_o(pbus), .neg_route_o(nroute), .neg_chan_o(nchan),
      .input_sense_ground_pin_oe_o(oe), .chan_count_o(ccount),
      .host_irq_o(irq)
   );
   // 250 mhz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // hang guard: tests need under three hundred cycles
   always @(posedge clk_sys_i) begin
      n_cycles++;
      if (n_cycles == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // compare one value, report mismatch at once
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // strobe a config word in; pins stay put until the next write
   task automatic cfg_write(input logic [6:0] d, input logic bs,
                            input logic ib);
      @(posedge clk_sys_i);
      cfg_data_i <= d;
      bus_sel_i <= bs;
      in_bin_i <= ib;
      repeat (2) @(posedge clk_sys_i);
      cfg_wr_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      cfg_wr_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      #1;
   endtask : cfg_write
   // select a channel and gain, let routing settle
   task automatic set_chan(input logic [2:0] c);
      @(posedge clk_sys_i);
      chan_i <= c;
      gain_i <= c[1:0];
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask : set_chan
   // hold reset 20 cycles and check the default state inside it
   task automatic do_reset;
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      check(8'(cfg_o), 8'(RST_CFG));
      check(8'(bsel), 8'h00);
      check(8'(ccount), 8'(CHANS_SINGLE));
      check(8'(oe), 8'h01);
      check(8'({o0u, o1u, iuni, irq}), 8'h00);
      rst_i <= 1'b0;
   endtask : do_reset
   // print counts and verdict, end the run
   task automatic tally_and_finish;
      $display("TB: compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [6:0] d;
      logic pr;
      rst_i = 1'b1;
      cfg_wr_i = 1'b0;
      cfg_data_i = 7'h00;
      bus_sel_i = 1'b0;
      in_bin_i = 1'b0;
      chan_i = 3'h0;
      gain_i = 2'h0;
      acq_done_i = 1'b0;
      irq_ack_i = 1'b0;
      do_reset();
      // every mode code, every channel; output bits set independently
      for (int m = 0; m < 4; m++) begin
         d = {m[1:0], opts[m]};
         pr = (m == 2);
         cfg_write(d, 1'b0, m[0]);
         check(8'(cfg_o), 8'(d));
         check(8'({o1u, o0u}), 8'(d[1:0]));
         check(8'({o1b, o0b}), 8'(d[3:2]));
         check(8'({iuni, ibin}), 8'({d[4], m[0]}));
         for (int c = 0; c < 8; c++) begin
            set_chan(3'(c));
            check(8'(pchan), pr ? 8'((c & 3) * 2) : 8'(c));
            check(8'(ccount), pr ? 8'h04 : 8'h08);
            check(8'(pbus), 8'h00);
            if (pr) begin
               check(8'(nchan), 8'((c & 3) * 2 + 1));
               check(8'(nroute), 8'(NEG_CHAN));
            end else begin
               check(8'(nroute), 8'((m == 1) ? 2'h1 : 2'h0));
               check(8'(oe), 8'(m != 1));
            end
         end
      end
      // backplane bus overrides mode, range and gain still apply
      for (int m = 1; m < 3; m++) begin
         cfg_write({m[1:0], m[0], 4'h0}, 1'b1, 1'b0);
         set_chan(3'h6);
         check(8'(bsel), 8'h01);
         check(8'({pbus, nroute}), 8'({1'b1, NEG_BUS}));
         check(8'({iuni, igain}), 8'({m[0], 2'h2}));
      end
      // coding paired with polarity the way software should set it
      cfg_write(7'h00, 1'b0, 1'b0);
      check(8'({o1b, o0b, o1u, o0u}), 8'h00);
      cfg_write(7'h0f, 1'b0, 1'b1);
      check(8'({o1b, o0b, o1u, o0u}), 8'h0f);
      // held strobe must not rewrite; falling edge neither
      @(posedge clk_sys_i);
      cfg_data_i <= 7'h2a;
      bus_sel_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      cfg_wr_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      cfg_data_i <= 7'h15;
      repeat (5) @(posedge clk_sys_i);
      cfg_wr_i <= 1'b0;
      #1 check(8'(cfg_o), 8'h2a);
      repeat (5) @(posedge clk_sys_i);
      #1 check(8'(cfg_o), 8'h2a);
      cfg_write(7'h15, 1'b0, 1'b0);
      check(8'(cfg_o), 8'h15);
      // interrupt: set, set beats clear, then clear
      @(posedge clk_sys_i);
      acq_done_i <= 1'b1;
      @(posedge clk_sys_i);
      acq_done_i <= 1'b0;
      #1 check(8'(irq), 8'h01);
      repeat (4) @(posedge clk_sys_i);
      irq_ack_i <= 1'b1;
      acq_done_i <= 1'b1;
      @(posedge clk_sys_i);
      acq_done_i <= 1'b0;
      #1 check(8'(irq), 8'h01);
      @(posedge clk_sys_i);
      irq_ack_i <= 1'b0;
      #1 check(8'(irq), 8'h00);
      // mid-run reset brings defaults back
      do_reset();
      repeat (3) @(posedge clk_sys_i);
      tally_and_finish();
   end
endmodule : aioc_ctrl_tb_top
